//--- hw/slot_signal_pkg.sv
// Constants, register map and state type for the slot signal logic.
// Assumes a 32-bit classic Wishbone register bus and one 25 MHz core clock.
package slot_signal_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int         ADDR_W        = 4;
  localparam int         DATA_W        = 32;
  localparam int         SEL_W         = 4;
  localparam logic [3:0] CTRL_ADDR     = 4'h0;
  localparam logic [3:0] STATUS_ADDR   = 4'h4;
  localparam logic [3:0] CAP_ADDR      = 4'h8;
  localparam int         WORD_LSB      = 2;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int         CTRL_W           = 6;
  localparam int         CTRL_RESET_BIT   = 0;
  localparam int         CTRL_BUS_EN_BIT  = 1;
  localparam int         CTRL_CLK_EN_BIT  = 2;
  localparam int         CTRL_SPEED_BIT   = 3;
  localparam int         CTRL_ATTN_BIT    = 4;
  localparam int         CTRL_POWER_BIT   = 5;
  localparam logic [5:0] CTRL_RESET_VALUE = 6'h01;

  // ---------------------------------------------------------------
  // Status register fields
  // ---------------------------------------------------------------
  localparam int ST_BUTTON_BIT    = 0;
  localparam int ST_AUX_FAULT_BIT = 1;
  localparam int ST_DIRECT_BIT    = 2;
  localparam int ST_POWERED_BIT   = 3;
  localparam int ST_FAULT_BIT     = 4;
  localparam int ST_PRESENCE_BIT  = 5;
  localparam int ST_SPEED_IN_BIT  = 6;
  localparam int ST_SYSTEM_POWER_GOOD_BIT     = 7;
  localparam int ST_STATE_LSB     = 8;

  // ---------------------------------------------------------------
  // Capability decoding
  // ---------------------------------------------------------------
  localparam int         CAP_LEVEL_LSB = 0;
  localparam int         CAP_CODE_LSB  = 4;
  localparam int         SAMPLE_W      = 8;
  localparam int         LEVEL_W       = 3;
  localparam int         CODE_W        = 3;
  localparam logic [7:0] CAP_TH1       = 8'h33;
  localparam logic [7:0] CAP_TH2       = 8'h66;
  localparam logic [7:0] CAP_TH3       = 8'h99;
  localparam logic [7:0] CAP_TH4       = 8'hcc;
  localparam logic [2:0] LEVEL_0       = 3'h0;
  localparam logic [2:0] LEVEL_1       = 3'h1;
  localparam logic [2:0] LEVEL_2       = 3'h2;
  localparam logic [2:0] LEVEL_3       = 3'h3;
  localparam logic [2:0] LEVEL_4       = 3'h4;
  localparam logic [2:0] CODE_L0       = 3'h0;
  localparam logic [2:0] CODE_L1       = 3'h1;
  localparam logic [2:0] CODE_L2       = 3'h3;
  localparam logic [2:0] CODE_L3       = 3'h5;
  localparam logic [2:0] CODE_L4       = 3'h7;

  // Main power sequencing states
  typedef enum logic [2:0] {
    PWR_OFF,
    PWR_RAMP_UP,
    PWR_ON,
    PWR_RAMP_DOWN,
    PWR_FAULT
  } power_state_t;

endpackage

//--- hw/cap_level_decoder.sv
// Five-level card capability classifier.
// Assumes sample comes from a converter clocked by core_clk.
`timescale 1ns/1ps
`default_nettype none
module cap_level_decoder #(
  parameter int SAMPLE_W = slot_signal_pkg::SAMPLE_W
) (
  input  wire logic                               core_clk,
  input  wire logic                               reset,
  input  wire logic                               clk_en,
  input  wire logic [SAMPLE_W-1:0]                sample,
  output logic      [slot_signal_pkg::LEVEL_W-1:0] level,
  output logic      [slot_signal_pkg::CODE_W-1:0]  code
);

  logic [slot_signal_pkg::LEVEL_W-1:0] level_next;
  logic [slot_signal_pkg::CODE_W-1:0]  code_next;

  // ---------------------------------------------------------------
  // Threshold compare and code lookup
  // ---------------------------------------------------------------
  always_comb
  begin
    if (sample < SAMPLE_W'(slot_signal_pkg::CAP_TH1))
    begin
      level_next = slot_signal_pkg::LEVEL_0;
      code_next  = slot_signal_pkg::CODE_L0;
    end
    else if (sample < SAMPLE_W'(slot_signal_pkg::CAP_TH2))
    begin
      level_next = slot_signal_pkg::LEVEL_1;
      code_next  = slot_signal_pkg::CODE_L1;
    end
    else if (sample < SAMPLE_W'(slot_signal_pkg::CAP_TH3))
    begin
      level_next = slot_signal_pkg::LEVEL_2;
      code_next  = slot_signal_pkg::CODE_L2;
    end
    else if (sample < SAMPLE_W'(slot_signal_pkg::CAP_TH4))
    begin
      level_next = slot_signal_pkg::LEVEL_3;
      code_next  = slot_signal_pkg::CODE_L3;
    end
    else
    begin
      level_next = slot_signal_pkg::LEVEL_4;
      code_next  = slot_signal_pkg::CODE_L4;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      level <= slot_signal_pkg::LEVEL_0;
      code  <= slot_signal_pkg::CODE_L0;
    end
    else if (clk_en)
    begin
      level <= level_next;
      code  <= code_next;
    end
  end

endmodule // cap_level_decoder
`default_nettype wire

//--- hw/slot_signal_mode_logic.sv
// Slot A signal logic: mode latch, shared pins, main power sequencing, status.
// Assumes a classic Wishbone master, analog comparators and pins asynchronous to core_clk.
//
// Operation
// - Serial mode: low button pin sets a sticky button-pressed status bit.
// - Direct mode: asserted power request turns slot main power on.
// - Direct mode: deasserting power request clears the latched slot fault.
// - Serial mode: speed line is an input monitoring 66-MHz operation.
// - Serial mode: clock switch enable makes speed line an open-drain output of selected mode.
// - Powered status goes high only after both gate drives ramp high.
// - Powered status goes low on aux or main over-current while powered.
// - At turn-off powered status falls only once all supplies are below low threshold.
// - Capability sense is classified into one of five levels.
// - Serial mode: slot reset driven by a push-pull output.
// - Direct mode: capability code bit 3 appears on slot reset pin.
// - Serial mode: presence detect bit 2 sampled through the shared pin.
// - Direct mode: aux fault pin flags aux fault when logic supply is off.
// - Mode select captured on rising edge of system power good.
// - Direct mode: capability bits 1 and 2 appear on bus and clock switch pins.
// - Direct mode with power good: slot fault pin shows aux or main fault.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module slot_signal_mode_logic #(
  parameter int SAMPLE_W = slot_signal_pkg::SAMPLE_W
) (
  input  wire logic                                core_clk,
  input  wire logic                                reset,
  input  wire logic                                clk_en,
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [slot_signal_pkg::ADDR_W-1:0]  wb_adr_i,
  input  wire logic [slot_signal_pkg::SEL_W-1:0]   wb_sel_i,
  input  wire logic [slot_signal_pkg::DATA_W-1:0]  wb_dat_i,
  output logic      [slot_signal_pkg::DATA_W-1:0]  wb_dat_o,
  output logic                                     wb_ack_o,
  input  wire logic                                system_power_good,
  input  wire logic                                interface_select,
  input  wire logic                                button_request_n,
  input  wire logic                                slot_speed_line_in,
  output logic                                     slot_speed_line_out,
  output logic                                     slot_speed_line_oe,
  input  wire logic                                presence_aux_in,
  output logic                                     presence_aux_out,
  output logic                                     presence_aux_oe,
  output logic                                     slot_fault_out,
  output logic                                     slot_fault_oe,
  output logic                                     slot_powered_status,
  output logic                                     bus_switch_pin,
  output logic                                     slot_clock_switch_enable,
  output logic                                     slot_reset_out,
  output logic                                     attention_indicator,
  output logic                                     main_power_enable,
  input  wire logic [SAMPLE_W-1:0]                 card_capability_sense,
  input  wire logic                                gate_drive_12v,
  input  wire logic                                gate_drive_5v_3v,
  input  wire logic                                supplies_below_low,
  input  wire logic                                aux_overcurrent,
  input  wire logic                                main_overcurrent,
  input  wire logic                                logic_supply
);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  localparam int SYNC_N = 11;
  localparam int S_PG   = 0;
  localparam int S_SEL  = 1;
  localparam int S_BTN  = 2;
  localparam int S_SPD  = 3;
  localparam int S_PRS  = 4;
  localparam int S_G12  = 5;
  localparam int S_G53  = 6;
  localparam int S_LOW  = 7;
  localparam int S_AOC  = 8;
  localparam int S_MOC  = 9;
  localparam int S_LSUP = 10;

  logic [SYNC_N-1:0] async_in;
  logic [SYNC_N-1:0] sync1_reg;
  logic [SYNC_N-1:0] sync2_reg;

  assign async_in = {logic_supply, main_overcurrent, aux_overcurrent, supplies_below_low,
                     gate_drive_5v_3v, gate_drive_12v, presence_aux_in, slot_speed_line_in,
                     button_request_n, interface_select, system_power_good};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi++)
    begin : g_sync
      always_ff @(posedge core_clk)
      begin
        if (reset)
        begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          sync1_reg[gi] <= async_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic pg_s;
  logic btn_s;
  logic lsup_s;
  logic overcurrent;
  assign pg_s        = sync2_reg[S_PG];
  assign btn_s       = sync2_reg[S_BTN];
  assign lsup_s      = sync2_reg[S_LSUP];
  assign overcurrent = sync2_reg[S_AOC] | sync2_reg[S_MOC];

  // ---------------------------------------------------------------
  // Mode latch on power good rise
  // ---------------------------------------------------------------
  logic pg_prev_reg;
  logic btn_prev_reg;
  logic direct_reg;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pg_prev_reg  <= 1'b0;
      btn_prev_reg <= 1'b0;
      direct_reg   <= 1'b0;
    end
    else if (clk_en)
    begin
      pg_prev_reg  <= pg_s;
      btn_prev_reg <= btn_s;
      if (pg_s && !pg_prev_reg)
        direct_reg <= sync2_reg[S_SEL];
    end
  end

  // ---------------------------------------------------------------
  // Capability decoder
  // ---------------------------------------------------------------
  logic [slot_signal_pkg::LEVEL_W-1:0] cap_level;
  logic [slot_signal_pkg::CODE_W-1:0]  cap_code;

  cap_level_decoder #(
    .SAMPLE_W (SAMPLE_W)
  ) u_cap (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .sample   (card_capability_sense),
    .level    (cap_level),
    .code     (cap_code)
  );

  // ---------------------------------------------------------------
  // Bus slave decode
  // ---------------------------------------------------------------
  logic [slot_signal_pkg::CTRL_W-1:0] ctrl_reg;
  logic                               ack_reg;
  logic                               wr_ctrl;
  logic                               wr_status;
  logic                               bus_req;

  assign bus_req   = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_ctrl   = bus_req && wb_we_i && wb_sel_i[0] &&
                     (wb_adr_i == slot_signal_pkg::CTRL_ADDR);
  assign wr_status = bus_req && wb_we_i && wb_sel_i[0] &&
                     (wb_adr_i == slot_signal_pkg::STATUS_ADDR);

  always_ff @(posedge core_clk)
  begin
    if (reset)
      ctrl_reg <= slot_signal_pkg::CTRL_RESET_VALUE;
    else if (clk_en && wr_ctrl)
      ctrl_reg <= wb_dat_i[slot_signal_pkg::CTRL_W-1:0];
  end

  // ---------------------------------------------------------------
  // Sticky button and aux fault flags, set wins over clear
  // ---------------------------------------------------------------
  logic button_reg;
  logic aux_fault_reg;
  logic button_set;
  logic button_clr;
  logic aux_clr;

  assign button_set = !direct_reg && !btn_s && btn_prev_reg;
  assign button_clr = wr_status && wb_dat_i[slot_signal_pkg::ST_BUTTON_BIT];
  assign aux_clr    = wr_status && wb_dat_i[slot_signal_pkg::ST_AUX_FAULT_BIT];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      button_reg    <= 1'b0;
      aux_fault_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      button_reg    <= (button_reg && !button_clr) || button_set;
      aux_fault_reg <= (aux_fault_reg && !aux_clr) || sync2_reg[S_AOC];
    end
  end

  // ---------------------------------------------------------------
  // Main power sequencing
  // ---------------------------------------------------------------
  slot_signal_pkg::power_state_t state_reg;
  logic                          power_req;
  logic                          fault_reg;
  logic                          powered_reg;

  assign power_req = direct_reg ? !btn_s : ctrl_reg[slot_signal_pkg::CTRL_POWER_BIT];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_reg   <= slot_signal_pkg::PWR_OFF;
      powered_reg <= 1'b0;
      fault_reg   <= 1'b0;
    end
    else if (clk_en)
    begin
      unique case (state_reg)
        slot_signal_pkg::PWR_OFF:
        begin
          if (power_req)
            state_reg <= slot_signal_pkg::PWR_RAMP_UP;
        end
        slot_signal_pkg::PWR_RAMP_UP:
        begin
          if (overcurrent)
          begin
            state_reg <= slot_signal_pkg::PWR_FAULT;
            fault_reg <= 1'b1;
          end
          else if (!power_req)
            state_reg <= slot_signal_pkg::PWR_RAMP_DOWN;
          else if (sync2_reg[S_G12] && sync2_reg[S_G53])
          begin
            state_reg   <= slot_signal_pkg::PWR_ON;
            powered_reg <= 1'b1;
          end
        end
        slot_signal_pkg::PWR_ON:
        begin
          if (overcurrent)
          begin
            state_reg   <= slot_signal_pkg::PWR_FAULT;
            fault_reg   <= 1'b1;
            powered_reg <= 1'b0;
          end
          else if (!power_req)
            state_reg <= slot_signal_pkg::PWR_RAMP_DOWN;
        end
        slot_signal_pkg::PWR_RAMP_DOWN:
        begin
          if (sync2_reg[S_LOW])
          begin
            state_reg   <= slot_signal_pkg::PWR_OFF;
            powered_reg <= 1'b0;
          end
        end
        slot_signal_pkg::PWR_FAULT:
        begin
          if (!power_req)
          begin
            state_reg <= slot_signal_pkg::PWR_OFF;
            fault_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registered pin drivers
  // ---------------------------------------------------------------
  logic on_state;
  assign on_state = (state_reg == slot_signal_pkg::PWR_RAMP_UP) || (state_reg == slot_signal_pkg::PWR_ON);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      main_power_enable        <= 1'b0;
      slot_powered_status      <= 1'b0;
      bus_switch_pin           <= 1'b0;
      slot_clock_switch_enable <= 1'b0;
      slot_reset_out           <= 1'b0;
      slot_speed_line_out      <= 1'b0;
      slot_speed_line_oe       <= 1'b0;
      presence_aux_out         <= 1'b0;
      presence_aux_oe          <= 1'b0;
      slot_fault_out           <= 1'b0;
      slot_fault_oe            <= 1'b0;
      attention_indicator      <= 1'b0;
    end
    else if (clk_en)
    begin
      main_power_enable   <= on_state;
      slot_powered_status <= powered_reg;
      if (direct_reg)
      begin
        bus_switch_pin           <= cap_code[0];
        slot_clock_switch_enable <= cap_code[1];
        slot_reset_out           <= cap_code[2];
      end
      else
      begin
        bus_switch_pin           <= ctrl_reg[slot_signal_pkg::CTRL_BUS_EN_BIT];
        slot_clock_switch_enable <= ctrl_reg[slot_signal_pkg::CTRL_CLK_EN_BIT];
        slot_reset_out           <= !ctrl_reg[slot_signal_pkg::CTRL_RESET_BIT];
      end
      slot_speed_line_out <= 1'b0;
      slot_speed_line_oe  <= !direct_reg && ctrl_reg[slot_signal_pkg::CTRL_CLK_EN_BIT] &&
                             !ctrl_reg[slot_signal_pkg::CTRL_SPEED_BIT];
      presence_aux_out    <= 1'b0;
      presence_aux_oe     <= direct_reg && aux_fault_reg && !lsup_s;
      slot_fault_out      <= 1'b0;
      slot_fault_oe       <= direct_reg && pg_s && (fault_reg || aux_fault_reg);
      attention_indicator <= ctrl_reg[slot_signal_pkg::CTRL_ATTN_BIT] ||
                             (aux_fault_reg && !(direct_reg && !lsup_s));
    end
  end

  // ---------------------------------------------------------------
  // Read data and acknowledge
  // ---------------------------------------------------------------
  logic [slot_signal_pkg::DATA_W-1:0] status_word;
  logic [slot_signal_pkg::DATA_W-1:0] cap_word;
  logic [slot_signal_pkg::DATA_W-1:0] rd_next;

  always_comb
  begin
    status_word = '0;
    status_word[slot_signal_pkg::ST_BUTTON_BIT]    = button_reg;
    status_word[slot_signal_pkg::ST_AUX_FAULT_BIT] = aux_fault_reg;
    status_word[slot_signal_pkg::ST_DIRECT_BIT]    = direct_reg;
    status_word[slot_signal_pkg::ST_POWERED_BIT]   = powered_reg;
    status_word[slot_signal_pkg::ST_FAULT_BIT]     = fault_reg;
    status_word[slot_signal_pkg::ST_PRESENCE_BIT]  = !direct_reg && sync2_reg[S_PRS];
    status_word[slot_signal_pkg::ST_SPEED_IN_BIT]  = !direct_reg && sync2_reg[S_SPD];
    status_word[slot_signal_pkg::ST_SYSTEM_POWER_GOOD_BIT]     = pg_s;
    status_word[slot_signal_pkg::ST_STATE_LSB +: 3] = state_reg;
    cap_word = '0;
    cap_word[slot_signal_pkg::CAP_LEVEL_LSB +: slot_signal_pkg::LEVEL_W] = cap_level;
    cap_word[slot_signal_pkg::CAP_CODE_LSB +: slot_signal_pkg::CODE_W]   = cap_code;
    unique case (wb_adr_i)
      slot_signal_pkg::CTRL_ADDR:   rd_next = {{(slot_signal_pkg::DATA_W-slot_signal_pkg::CTRL_W){1'b0}}, ctrl_reg};
      slot_signal_pkg::STATUS_ADDR: rd_next = status_word;
      slot_signal_pkg::CAP_ADDR:    rd_next = cap_word;
      default:                      rd_next = '0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ack_reg  <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else if (clk_en)
    begin
      ack_reg  <= bus_req;
      wb_ack_o <= bus_req;
      if (bus_req)
        wb_dat_o <= rd_next;
    end
  end

endmodule // slot_signal_mode_logic
`default_nettype wire

//--- test/slot_far_side.sv
// Far-side model: slot card speed line, gate ramps and button or request pin.
// Assumes the slot logic drives main_power_enable and the speed line enable.
`timescale 1ns/1ps
`default_nettype none
module slot_far_side #(
  parameter int RAMP = 6
) (
  input  wire logic core_clk,
  input  wire logic main_power_enable,
  input  wire logic press,
  input  wire logic card_66,
  input  wire logic speed_oe,
  output logic      button_n,
  output logic      speed_line,
  output logic      gate_12v,
  output logic      gate_5v_3v,
  output logic      below_low
);
  int ramp_cnt = 0;
  // Pull-up keeps the pin high unless pressed or requested
  assign button_n   = !press;
  assign speed_line = speed_oe ? 1'b0 : card_66;
  assign gate_12v   = ramp_cnt >= RAMP - 1;
  assign gate_5v_3v = ramp_cnt == RAMP;
  assign below_low  = ramp_cnt == 0;
  always @(posedge core_clk)
  begin
    if (main_power_enable && ramp_cnt < RAMP) ramp_cnt <= ramp_cnt + 1;
    else if (!main_power_enable && ramp_cnt > 0) ramp_cnt <= ramp_cnt - 1;
  end
endmodule // slot_far_side
`default_nettype wire

//--- test/slot_signal_mode_logic_assertions.sv
// Checker for the slot signal logic top ports.
// Assumes one clock core_clk and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module slot_signal_checks (
  input wire logic core_clk, reset, clk_en, wb_cyc_i, wb_stb_i, wb_ack_o,
  input wire logic system_power_good, slot_speed_line_out, slot_speed_line_oe, slot_clock_switch_enable,
  input wire logic presence_aux_oe, logic_supply, slot_fault_oe, slot_powered_status,
  input wire logic main_power_enable, gate_drive_12v, gate_drive_5v_3v,
  input wire logic supplies_below_low, aux_overcurrent, main_overcurrent
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  logic [2:0] hist_q;
  always_ff @(posedge core_clk)
  begin
    if (reset) hist_q <= 3'h7;
    else hist_q <= {hist_q[1:0], aux_overcurrent | main_overcurrent | supplies_below_low};
  end
  sequence bus_take;
    $rose(wb_cyc_i && wb_stb_i) && clk_en;
  endsequence
  sequence quiet_down;
    slot_powered_status && !main_power_enable && hist_q == 3'h0
      && !(aux_overcurrent || main_overcurrent || supplies_below_low);
  endsequence
  chk_ack_latency: assert property (bus_take |=> wb_ack_o) else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  chk_powered_gates: assert property ($rose(slot_powered_status) |->
    $past(gate_drive_12v) && $past(gate_drive_5v_3v)) else $error("powered before gates");
  chk_fault_drop: assert property (slot_powered_status && (aux_overcurrent || main_overcurrent)
    |-> ##[1:6] !slot_powered_status) else $error("powered kept on fault");
  chk_off_wait: assert property (quiet_down |=> slot_powered_status) else $error("off early");
  chk_fault_system_power_good: assert property (slot_fault_oe |->
    $past(system_power_good, 2) || $past(system_power_good, 3)) else $error("fault without system_power_good");
  chk_aux_supply: assert property (presence_aux_oe |->
    !$past(logic_supply, 2) || !$past(logic_supply, 3)) else $error("aux flag with supply");
  chk_speed_drive: assert property (slot_speed_line_oe |->
    slot_clock_switch_enable && !slot_speed_line_out) else $error("speed drive");
endmodule // slot_signal_checks
bind slot_signal_mode_logic slot_signal_checks slot_signal_checks_inst (.*);
`default_nettype wire

//--- test/slot_signal_mode_logic_test.sv
// Testbench for the slot signal logic: serial then direct mode.
// Assumes the far-side model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module slot_signal_mode_logic_test;
  logic core_clk = 0, reset = 1, clk_en = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, system_power_good = 0, interface_select = 0, button_request_n, slot_speed_line_in;
  logic slot_speed_line_out, slot_speed_line_oe, presence_aux_in, presence_aux_out, presence_aux_oe;
  logic slot_fault_out, slot_fault_oe, slot_powered_status, bus_switch_pin, slot_clock_switch_enable;
  logic slot_reset_out, attention_indicator, main_power_enable, gate_drive_12v, gate_drive_5v_3v;
  logic supplies_below_low, aux_overcurrent = 0, main_overcurrent = 0, logic_supply = 1;
  logic press = 0, card_66 = 0, pres = 1;
  logic [7:0] card_capability_sense = 8'h00;
  int mismatches = 0, checks_done = 0, cycles = 0;
  logic [7:0] samp [5] = '{8'h10, 8'h40, 8'h80, 8'hb0, 8'hf0};
  logic [2:0] codes [5] = '{slot_signal_pkg::CODE_L0, slot_signal_pkg::CODE_L1,
    slot_signal_pkg::CODE_L2, slot_signal_pkg::CODE_L3, slot_signal_pkg::CODE_L4};
  assign presence_aux_in = presence_aux_oe ? 1'b0 : pres;
  always #20 core_clk = ~core_clk;
  slot_signal_mode_logic slot_signal_mode_logic_inst (.*);
  slot_far_side slot_far_side_inst (.core_clk, .main_power_enable, .press, .card_66,
    .speed_oe(slot_speed_line_oe), .button_n(button_request_n), .speed_line(slot_speed_line_in),
    .gate_12v(gate_drive_12v), .gate_5v_3v(gate_drive_5v_3v), .below_low(supplies_below_low));
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      mismatches++;
      close_out;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task xfer(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask
  task st(input int b, input logic e);
    tick(2);
    xfer(0, slot_signal_pkg::STATUS_ADDR, 32'h0);
    check(32'(q[b]), 32'(e));
  endtask
  task set_mode(input logic sel);
    system_power_good <= 0;
    tick(4);
    interface_select <= sel;
    tick(2);
    system_power_good <= 1;
    tick(6);
  endtask
  task wait_pwr(input logic v);
    for (int n = 0; n < 60 && slot_powered_status !== v; n++) @(posedge core_clk);
    check(32'(slot_powered_status), 32'(v));
  endtask
  task pins(input logic [7:0] s, input logic [2:0] e);
    card_capability_sense <= s;
    tick(6);
    check(32'({slot_reset_out, slot_clock_switch_enable, bus_switch_pin}), 32'(e));
  endtask
  initial
  begin
    tick(6);
    reset <= 0;
    set_mode(0);
    st(slot_signal_pkg::ST_DIRECT_BIT, 0);
    st(slot_signal_pkg::ST_BUTTON_BIT, 0);
    xfer(0, slot_signal_pkg::CTRL_ADDR, 32'h0);
    check(q, 32'h1);
    check(32'(slot_reset_out), 32'h0);
    xfer(1, slot_signal_pkg::CTRL_ADDR, 32'h0);
    tick(2);
    check(32'(slot_reset_out), 32'h1);
    pres <= 0;
    st(slot_signal_pkg::ST_PRESENCE_BIT, 0);
    pres <= 1;
    card_66 <= 1;
    st(slot_signal_pkg::ST_PRESENCE_BIT, 1);
    st(slot_signal_pkg::ST_SPEED_IN_BIT, 1);
    xfer(1, slot_signal_pkg::CTRL_ADDR, 32'h4);
    tick(2);
    check(32'(slot_speed_line_oe), 32'h1);
    xfer(1, slot_signal_pkg::CTRL_ADDR, 32'hc);
    tick(2);
    check(32'(slot_speed_line_oe), 32'h0);
    press <= 1;
    tick(6);
    press <= 0;
    st(slot_signal_pkg::ST_BUTTON_BIT, 1);
    xfer(1, slot_signal_pkg::STATUS_ADDR, 32'h1);
    st(slot_signal_pkg::ST_BUTTON_BIT, 0);
    xfer(0, 4'hc, 32'h0);
    check(q, 32'h0);
    for (int i = 0; i < 5; i++)
    begin
      card_capability_sense <= samp[i];
      tick(4);
      xfer(0, slot_signal_pkg::CAP_ADDR, 32'h0);
      check(q, (32'(codes[i]) << slot_signal_pkg::CAP_CODE_LSB) | (32'(i) << slot_signal_pkg::CAP_LEVEL_LSB));
    end
    $display("serial mode test done");
    set_mode(1);
    st(slot_signal_pkg::ST_DIRECT_BIT, 1);
    pins(8'hf0, 3'h7);
    pins(8'h40, 3'h1);
    press <= 1;
    wait_pwr(1);
    check(32'(main_power_enable), 32'h1);
    main_overcurrent <= 1;
    tick(2);
    main_overcurrent <= 0;
    wait_pwr(0);
    tick(4);
    check(32'(slot_fault_oe), 32'h1);
    press <= 0;
    tick(6);
    check(32'(slot_fault_oe), 32'h0);
    press <= 1;
    wait_pwr(1);
    press <= 0;
    tick(3);
    check(32'(slot_powered_status), 32'h1);
    wait_pwr(0);
    logic_supply <= 0;
    aux_overcurrent <= 1;
    tick(2);
    aux_overcurrent <= 0;
    tick(4);
    check(32'(presence_aux_oe), 32'h1);
    check(32'(attention_indicator), 32'h0);
    logic_supply <= 1;
    tick(4);
    check(32'(presence_aux_oe), 32'h0);
    check(32'(attention_indicator), 32'h1);
    $display("direct mode test done");
    close_out;
  end
endmodule // slot_signal_mode_logic_test
`default_nettype wire
